/* File: core/eia_arb_if.sv */
// signals between the sequencer and the request arbiter
`timescale 1ns/10ps
interface eia_arb_if;
	logic [eia_pkg::N_SRC:1]   req;       // raw request levels
	logic [eia_pkg::N_SRC:1]   enable;    // per-source enables
	logic                      take;      // entry decided this cycle
	logic                      release_l; // latched request serviced or reset
	logic                      hit_valid; // a winner exists
	logic [eia_pkg::SRC_W-1:0] hit_idx;   // winner index
	logic                      lat_valid; // a winner is latched
	logic [eia_pkg::SRC_W-1:0] lat_idx;   // latched index
	modport arb (input req, enable, take, release_l,
		output hit_valid, hit_idx, lat_valid, lat_idx);
	modport seq (output req, enable, take, release_l,
		input hit_valid, hit_idx, lat_valid, lat_idx);
endinterface

/* File: core/eia_arbiter.sv */
// fixed priority arbiter with a winner latch
`timescale 1ns/10ps
module eia_arbiter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	eia_arb_if.arb   arb
);
	logic [eia_pkg::N_SRC:1]   live;       // enabled requests
	logic [eia_pkg::SRC_W-1:0] live_idx;   // best live request
	logic                      lat_valid;  // latch holds a winner
	logic [eia_pkg::SRC_W-1:0] lat_idx;    // latched winner

	assign live     = arb.req & arb.enable;
	assign live_idx = eia_pkg::eia_first(live);
	// a latched winner shadows any newcomer, whatever its priority
	assign arb.hit_valid = lat_valid | (|live);
	assign arb.hit_idx   = lat_valid ? lat_idx : live_idx;
	assign arb.lat_valid = lat_valid;
	assign arb.lat_idx   = lat_idx;

	// capture on take, drop on service; take wins over release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat_valid <= 1'b0;
			lat_idx   <= '0;
		end else if (ce) begin
			if (arb.take && arb.hit_valid) begin
				lat_valid <= 1'b1;
				lat_idx   <= arb.hit_idx;
			end else if (arb.release_l) begin
				lat_valid <= 1'b0;
			end
		end
	end
endmodule

/* File: core/eia_pkg.sv */
// constants and helpers shared by the exception interrupt arbiter
// How it works
// - entry stacks registers, then sets global mask
// - return pops stack to restore cpu registers
// - requests latched; arbitration at processing start
// - winner given to cpu as vector code
// - latched winner never displaced before service
// - hardware entry waits for instruction completion
// - boundary: enter only if unmasked and enabled
// - lowest priority number wins; zero is highest
// - pending request taken right after return
// - high index byte never stacked on entry
// - software interrupt always enters, mask ignored
// - software stacks pc; hardware stacks pc-1
// - global mask gates all but software interrupt
// - pending flag reads one while request present
// - low register: sources 1-6, bits 1:0 zero
// - mid_a register holds sources 7 to 14
// - mid_b register holds sources 15 to 22
// - high register: sources 23-24, bits 7:2 zero
// - reset pre-empts everything, bypasses arbitration
package eia_pkg;
	localparam int           N_SRC       = 24;            // hardware sources 1..24
	localparam int           SRC_W       = 5;             // width of a source index
	localparam int           CODE_W      = 5;             // width of a vector code
	localparam int           ADDR_W      = 8;             // apb address bits decoded
	localparam logic [15:0]  VEC_TOP     = 16'hFFFE;      // vector of code zero
	localparam logic [4:0]   CODE_RESET  = 5'h00;         // reset vector code
	localparam logic [4:0]   CODE_SWI    = 5'h01;         // software interrupt code
	localparam logic [4:0]   CODE_HW_OFS = 5'h01;         // code = source index + this
	localparam int           CCR_I_BIT   = 3;             // global mask bit in ccr
	localparam logic [2:0]   CNT_LAST    = 3'h4;          // five stack bytes: 0..4
	localparam logic [2:0]   CNT_ONE     = 3'h1;          // counter step
	// byte addresses of the register words
	localparam logic [7:0]   ADDR_PEND_LOW   = 8'h00;
	localparam logic [7:0]   ADDR_PEND_MID_A = 8'h04;
	localparam logic [7:0]   ADDR_PEND_MID_B = 8'h08;
	localparam logic [7:0]   ADDR_PEND_HIGH  = 8'h0C;
	localparam logic [7:0]   ADDR_ENABLE     = 8'h10;
	localparam logic [7:0]   ADDR_STATE      = 8'h14;
	localparam logic [31:0]  ENABLE_RESET    = 32'h01FFFFFE; // all sources enabled
	localparam logic [31:0]  ENABLE_MASK     = 32'h01FFFFFE; // bits 24:1 writable
	localparam int           STATE_VALID_BIT = 8;            // latch valid in state word
	// source ranges of each status register
	localparam int LOW_FIRST = 1;
	localparam int LOW_LAST  = 6;
	localparam int MIDA_FIRST = 7;
	localparam int MIDA_LAST  = 14;
	localparam int MIDB_FIRST = 15;
	localparam int MIDB_LAST  = 22;
	localparam int HIGH_FIRST = 23;
	localparam int HIGH_LAST  = 24;

	// lowest set index of a request vector, zero when none
	function automatic logic [SRC_W-1:0] eia_first(input logic [N_SRC:1] v);
		logic [SRC_W-1:0] r;
		r = '0;
		for (int i = N_SRC; i >= 1; i--) begin
			if (v[i]) begin
				r = SRC_W'(i);
			end
		end
		return r;
	endfunction

	// vector address of a code: two bytes down per step
	function automatic logic [15:0] eia_vec_addr(input logic [CODE_W-1:0] code);
		return VEC_TOP - {{(16-CODE_W-1){1'b0}}, code, 1'b0};
	endfunction
endpackage

/* File: core/eia_top.sv */
// exception control: request arbitration, stacking sequencer, apb status
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module eia_top (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [eia_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// peripheral requests
	input  wire logic [eia_pkg::N_SRC:1]     irq_req,
	// cpu core
	input  wire logic                        reset_req,
	input  wire logic                        instr_done,
	input  wire logic                        i_mask,
	input  wire logic                        swi_exec,
	input  wire logic                        rti_exec,
	input  wire logic [15:0]                 cpu_pc,
	input  wire logic [7:0]                  cpu_a,
	input  wire logic [7:0]                  cpu_x,
	input  wire logic [7:0]                  cpu_ccr,
	input  wire logic [7:0]                  pop_data,
	output logic                             hold_fetch,
	output logic                             stack_push,
	output logic      [7:0]                  stack_data,
	output logic                             stack_pop,
	output logic                             set_mask,
	output logic                             vector_valid,
	output logic      [eia_pkg::CODE_W-1:0]  vector_code,
	output logic      [15:0]                 vector_addr,
	output logic                             restore_valid,
	output logic      [15:0]                 rest_pc,
	output logic      [7:0]                  rest_a,
	output logic      [7:0]                  rest_x,
	output logic      [7:0]                  rest_ccr,
	output logic                             reset_take
);
	// one-hot sequencer states
	typedef enum logic [4:0] {
		EIA_IDLE  = 5'h01,   // running, watching boundaries
		EIA_PUSH  = 5'h02,   // stacking five bytes
		EIA_VECT  = 5'h04,   // presenting the vector, setting mask
		EIA_POP   = 5'h08,   // unstacking five bytes
		EIA_CHECK = 5'h10    // after return: chain or resume
	} eia_state_e;

	eia_arb_if arb_bus ();                          // link to the arbiter

	eia_state_e                 st;                 // current state
	eia_state_e                 next_st;            // next state
	logic [2:0]                 cnt;                // stack byte counter
	logic [15:0]                sv_pc;              // pc to be stacked
	logic [7:0]                 sv_a;               // accumulator to be stacked
	logic [7:0]                 sv_x;               // index low to be stacked
	logic [7:0]                 sv_ccr;             // ccr to be stacked
	logic [eia_pkg::CODE_W-1:0] code;               // code of the entry in flight
	logic                       code_hw;            // entry came from hardware
	logic [31:0]                en_reg;             // per-source enables
	logic                       data_fresh;         // prdata captured last cycle

	// ---------------- entry decode ----------------
	wire in_idle   = (st == EIA_IDLE);
	wire in_push   = (st == EIA_PUSH);
	wire in_vect   = (st == EIA_VECT);
	wire in_pop    = (st == EIA_POP);
	wire in_check  = (st == EIA_CHECK);
	wire cnt_last  = (cnt == eia_pkg::CNT_LAST);
	// software entry ignores the global mask entirely
	wire take_swi  = in_idle & ~reset_req & swi_exec;
	// hardware entry only at an instruction boundary, mask clear
	wire take_hw   = in_idle & ~reset_req & ~swi_exec & instr_done
		& ~i_mask & arb_bus.hit_valid;
	wire take_rti  = in_idle & ~reset_req & ~swi_exec & ~take_hw & rti_exec;
	// after a return the restored mask decides chaining, before any fetch
	wire take_chain = in_check & ~reset_req & ~rest_ccr[eia_pkg::CCR_I_BIT]
		& arb_bus.hit_valid;
	wire [eia_pkg::CODE_W-1:0] hw_code =
		eia_pkg::CODE_W'(arb_bus.hit_idx) + eia_pkg::CODE_HW_OFS;

	// ---------------- arbiter hookup ----------------
	assign arb_bus.req       = irq_req;
	assign arb_bus.enable    = en_reg[eia_pkg::N_SRC:1];
	assign arb_bus.take      = take_hw | take_chain;
	// latch held until its vector goes out; reset drops it too
	assign arb_bus.release_l = (in_vect & code_hw) | reset_req;

	eia_arbiter u_arb (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.arb     (arb_bus)
	);

	// ---------------- sequencer ----------------
	// reset aborts whatever is in flight and returns to idle
	always_comb begin
		next_st = st;
		case (st)
			EIA_IDLE: begin
				if (take_swi || take_hw) begin
					next_st = EIA_PUSH;
				end else if (take_rti) begin
					next_st = EIA_POP;
				end
			end
			EIA_PUSH: begin
				if (cnt_last) begin
					next_st = EIA_VECT;
				end
			end
			EIA_VECT:  next_st = EIA_IDLE;
			EIA_POP: begin
				if (cnt_last) begin
					next_st = EIA_CHECK;
				end
			end
			EIA_CHECK: begin
				next_st = take_chain ? EIA_PUSH : EIA_IDLE;
			end
			default:   next_st = EIA_IDLE;
		endcase
		if (reset_req) begin
			next_st = EIA_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= EIA_IDLE;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// stack byte counter, restarted on every state change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (ce) begin
			cnt <= (next_st != st || reset_req) ? '0 : cnt + eia_pkg::CNT_ONE;
		end
	end

	// ---------------- snapshot of what gets stacked ----------------
	// software stacks pc as is; hardware stacks pc-1 since the cpu has
	// already prefetched; on a chained entry the restored pc is that value
	wire [15:0] hw_pc = cpu_pc - 16'h0001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sv_pc   <= '0;
			sv_a    <= '0;
			sv_x    <= '0;
			sv_ccr  <= '0;
			code    <= eia_pkg::CODE_RESET;
			code_hw <= 1'b0;
		end else if (ce) begin
			if (take_swi) begin
				sv_pc   <= cpu_pc;
				code    <= eia_pkg::CODE_SWI;
				code_hw <= 1'b0;
			end else if (take_hw) begin
				sv_pc   <= hw_pc;
				code    <= hw_code;
				code_hw <= 1'b1;
			end else if (take_chain) begin
				sv_pc   <= rest_pc;
				code    <= hw_code;
				code_hw <= 1'b1;
			end
			if (take_swi || take_hw) begin
				sv_a    <= cpu_a;
				sv_x    <= cpu_x;
				sv_ccr  <= cpu_ccr;
			end else if (take_chain) begin
				sv_a    <= rest_a;
				sv_x    <= rest_x;
				sv_ccr  <= rest_ccr;
			end
		end
	end

	// push order pcl, pch, x, a, ccr; the high index byte has no slot
	wire [7:0] push_byte =
		(cnt == 3'h0) ? sv_pc[7:0]  :
		(cnt == 3'h1) ? sv_pc[15:8] :
		(cnt == 3'h2) ? sv_x        :
		(cnt == 3'h3) ? sv_a        : sv_ccr;

	// ---------------- cpu side outputs ----------------
	// stacking first, then the mask, in that order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_push   <= 1'b0;
			stack_data   <= '0;
			set_mask     <= 1'b0;
			vector_valid <= 1'b0;
			vector_code  <= eia_pkg::CODE_RESET;
			vector_addr  <= eia_pkg::VEC_TOP;
			reset_take   <= 1'b0;
		end else if (ce) begin
			stack_push   <= in_push & ~reset_req;
			stack_data   <= in_push ? push_byte : stack_data;
			set_mask     <= in_vect & ~reset_req;
			vector_valid <= (in_vect & ~reset_req) | reset_req;
			reset_take   <= reset_req;
			if (reset_req) begin
				vector_code <= eia_pkg::CODE_RESET;
				vector_addr <= eia_pkg::eia_vec_addr(eia_pkg::CODE_RESET);
			end else if (in_vect) begin
				vector_code <= code;
				vector_addr <= eia_pkg::eia_vec_addr(code);
			end
		end
	end

	// pop strobe is a handshake: the cpu drives pop_data in that cycle
	assign stack_pop  = in_pop & ~reset_req & ce;
	// no fetch while the sequencer owns the cpu
	assign hold_fetch = ~in_idle | take_swi | take_hw | take_rti;

	// unstack in reverse: ccr, a, x, pch, pcl
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rest_pc  <= '0;
			rest_a   <= '0;
			rest_x   <= '0;
			rest_ccr <= '0;
		end else if (ce && stack_pop) begin
			case (cnt)
				3'h0:    rest_ccr      <= pop_data;
				3'h1:    rest_a        <= pop_data;
				3'h2:    rest_x        <= pop_data;
				3'h3:    rest_pc[15:8] <= pop_data;
				default: rest_pc[7:0]  <= pop_data;
			endcase
		end
	end

	// restored set announced once, as the return finishes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restore_valid <= 1'b0;
		end else if (ce) begin
			restore_valid <= in_pop & cnt_last & ~reset_req;
		end
	end

	// ---------------- status words ----------------
	// flags follow raw request levels, each word's highest source in its top used bit (bit 1 in the high word)
	wire [7:0] pend_low   = {irq_req[eia_pkg::LOW_LAST:eia_pkg::LOW_FIRST], 2'b00};
	wire [7:0] pend_mid_a = irq_req[eia_pkg::MIDA_LAST:eia_pkg::MIDA_FIRST];
	wire [7:0] pend_mid_b = irq_req[eia_pkg::MIDB_LAST:eia_pkg::MIDB_FIRST];
	wire [7:0] pend_high  = {6'h00, irq_req[eia_pkg::HIGH_LAST:eia_pkg::HIGH_FIRST]};
	wire [31:0] state_word =
		{23'h000000, arb_bus.lat_valid, 3'h0, arb_bus.lat_idx};

	// ---------------- apb slave ----------------
	wire hit_low   = (paddr == eia_pkg::ADDR_PEND_LOW);
	wire hit_mid_a = (paddr == eia_pkg::ADDR_PEND_MID_A);
	wire hit_mid_b = (paddr == eia_pkg::ADDR_PEND_MID_B);
	wire hit_high  = (paddr == eia_pkg::ADDR_PEND_HIGH);
	wire hit_en    = (paddr == eia_pkg::ADDR_ENABLE);
	wire hit_state = (paddr == eia_pkg::ADDR_STATE);
	wire mapped    = hit_low | hit_mid_a | hit_mid_b | hit_high | hit_en | hit_state;
	wire [31:0] rd_mux =
		hit_low   ? {24'h000000, pend_low}   :
		hit_mid_a ? {24'h000000, pend_mid_a} :
		hit_mid_b ? {24'h000000, pend_mid_b} :
		hit_high  ? {24'h000000, pend_high}  :
		hit_en    ? en_reg                   :
		hit_state ? state_word               : 32'h00000000;
	// one access cycle when ce is high; ce low stretches the wait
	assign pready  = psel & penable & ce & data_fresh;
	assign pslverr = pready & ~mapped;
	wire   apb_done = pready;
	wire   apb_wr   = apb_done & pwrite & hit_en;

	// read data is sampled while the request is held, then shown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= '0;
			data_fresh <= 1'b0;
		end else if (ce) begin
			data_fresh <= psel & ~apb_done;
			if (psel && !apb_done) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	// enable word: only source bits are writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= eia_pkg::ENABLE_RESET;
		end else if (ce && apb_wr) begin
			en_reg <= pwdata & eia_pkg::ENABLE_MASK;
		end
	end
endmodule

/* File: sim/eia_assertions.sv */
// concurrent checks on the exception interrupt arbiter ports
`timescale 1ns/10ps
module eia_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        instr_done,
	input wire logic        i_mask,
	input wire logic        swi_exec,
	input wire logic        rti_exec,
	input wire logic        reset_req,
	input wire logic [24:1] irq_req,
	input wire logic        hold_fetch,
	input wire logic        stack_push,
	input wire logic        stack_pop,
	input wire logic        set_mask,
	input wire logic        vector_valid,
	input wire logic [4:0]  vector_code,
	input wire logic [15:0] vector_addr,
	input wire logic        reset_take
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a reset request aborts a sequence, so runs are judged only without one
	a_push_run: assert property (disable iff (!presetn || reset_req)
		$rose(stack_push) |-> stack_push [*5] ##1 (set_mask && vector_valid))
		else $error("push run is not five bytes then mask");
	a_pop_run: assert property (disable iff (!presetn || reset_req)
		$rose(stack_pop) |-> stack_pop [*5] ##1 !stack_pop)
		else $error("pop run is not five bytes");
	a_vec_addr: assert property (vector_valid |->
		vector_addr == 16'hFFFE - {10'h000, vector_code, 1'h0})
		else $error("vector address does not follow code");
	a_reset_vec: assert property (reset_req |=> reset_take && vector_valid
		&& vector_code == 5'h00 && vector_addr == 16'hFFFE)
		else $error("reset did not select top vector");
	a_hold_cause: assert property ($rose(hold_fetch) |-> (instr_done && !i_mask)
		|| swi_exec || rti_exec || $past(rti_exec) || reset_req)
		else $error("fetch held without a boundary");
	a_masked_idle: assert property (instr_done && i_mask && !swi_exec && !rti_exec
		&& !hold_fetch && !reset_req |-> !hold_fetch ##2 !stack_push)
		else $error("masked boundary started an entry");
	a_swi_entry: assert property (disable iff (!presetn || reset_req)
		swi_exec && !$past(hold_fetch) && ce |-> ##2 stack_push ##5
		(vector_valid && vector_code == 5'h01))
		else $error("software interrupt not entered");
	a_hw_code: assert property (disable iff (!presetn || reset_req)
		instr_done && !i_mask && !$past(hold_fetch) && !swi_exec && !rti_exec
		&& irq_req[3] && irq_req[2:1] == 2'h0 |-> ##7 vector_valid && vector_code == 5'h04)
		else $error("winning source code wrong");
	a_apb_wait: assert property ((psel && !penable && ce) ##1 (psel && penable && ce)
		|-> pready)
		else $error("apb access not answered at once");
	c_swi: cover property (vector_valid && vector_code == 5'h01);
	c_pop: cover property ($rose(stack_pop));
	c_reset: cover property (reset_take);
endmodule
bind eia_top eia_assertions chk (.*);

/* File: sim/eia_cpu_model.sv */
// cpu-side stack model: keeps pushed bytes and returns them on pops
`timescale 1ns/10ps
module eia_cpu_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       stack_push,
	input  wire logic [7:0] stack_data,
	input  wire logic       stack_pop,
	output logic      [7:0] pop_data
);
	logic [7:0] mem [256]; // stack bytes, grows downward
	logic [7:0] sp;        // next free byte
	// off a pop the bus shows inverted data so a stale byte is never trusted
	assign pop_data = stack_pop ? mem[sp + 8'h01] : ~mem[sp + 8'h01];
	// one byte per pulse, last in first out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp <= 8'hFF;
		end else if (stack_push) begin
			mem[sp] <= stack_data;
			sp <= sp - 8'h01;
		end else if (stack_pop) begin
			sp <= sp + 8'h01;
		end
	end
endmodule

/* File: sim/eia_tb_top.sv */
// self-checking bench for the exception interrupt arbiter
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module eia_tb_top;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, cpu_a, cpu_x, cpu_ccr, pop_data, stack_data, rest_a, rest_x, rest_ccr;
	logic [31:0] pwdata, prdata, rd;
	logic [24:1] irq_req;
	logic        reset_req, instr_done, i_mask, swi_exec, rti_exec, hold_fetch, er;
	logic        stack_push, stack_pop, set_mask, vector_valid, restore_valid, reset_take;
	logic [4:0]  vector_code;
	logic [15:0] cpu_pc, vector_addr, rest_pc;
	int          fail_count, n_checks, cyc;
	eia_top DUT (.*);
	eia_cpu_model cpu (.*);
	// free-running bus clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// one apb transfer; holds the request until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	// one-cycle pulse on {swi, rti, done}
	task automatic pulse(input logic [2:0] p);
		@(posedge pclk);
		{swi_exec, rti_exec, instr_done} <= p;
		@(posedge pclk);
		{swi_exec, rti_exec, instr_done} <= 3'h0;
	endtask
	// bounded wait for a vector, then compare its code
	task automatic wait_vec(input logic [4:0] code);
		int k;
		k = 0;
		while (vector_valid !== 1'b1 && k < 40) begin
			@(posedge pclk);
			k++;
		end
		`CHK("vector_code", code, vector_code)
	endtask
	// status words follow the raw request levels, packed from the top bit, except the high word packed from bit 0
	task automatic t_regs;
		logic [24:1] q;
		for (int i = 0; i < 2; i++) begin
			q = i ? 24'h5A3C96 : 24'hFFFFFF;
			irq_req <= q;
			apb(1'b1, 8'h00, 32'hFFFFFFFF);
			apb(1'b0, 8'h00, 32'h0);
			`CHK("pending_flags_low", {24'h0, q[6:1], 2'h0}, rd)
			apb(1'b0, 8'h04, 32'h0);
			`CHK("pending_flags_mid_a", {24'h0, q[14:7]}, rd)
			apb(1'b0, 8'h08, 32'h0);
			`CHK("pending_flags_mid_b", {24'h0, q[22:15]}, rd)
			apb(1'b0, 8'h0C, 32'h0);
			`CHK("pending_flags_high", {30'h0, q[24:23]}, rd)
		end
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped_err", 1'b1, er)
		irq_req <= '0;
		$display("test regs done");
	endtask
	// software interrupt while masked stacks pc itself
	task automatic t_swi;
		i_mask <= 1'b1;
		pulse(3'h4);
		wait_vec(5'h01);
		`CHK("swi_addr", 16'hFFFC, vector_addr)
		`CHK("swi_pcl", 8'h34, cpu.mem[8'hFF])
		`CHK("swi_pch", 8'h12, cpu.mem[8'hFE])
		`CHK("swi_depth", 8'hFA, cpu.sp)
		$display("test swi done");
	endtask
	// return restores registers, then a pending request chains in at once
	task automatic t_rti;
		int k;
		irq_req[3] <= 1'b1;
		pulse(3'h2);
		k = 0;
		while (restore_valid !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		`CHK("rest_pc", 16'h1234, rest_pc)
		`CHK("rest_regs", 24'hA15C00, {rest_a, rest_x, rest_ccr})
		wait_vec(5'h04);
		`CHK("chain_pcl", 8'h34, cpu.mem[8'hFF])
		irq_req <= '0;
		$display("test rti done");
	endtask
	// masked boundary and disabled source both leave the stack alone
	task automatic t_masked;
		logic [7:0] s;
		s = cpu.sp;
		irq_req[4] <= 1'b1;
		pulse(3'h1);
		repeat (10) @(posedge pclk);
		`CHK("masked_depth", s, cpu.sp)
		apb(1'b1, 8'h10, 32'h01FFFFEE);
		i_mask <= 1'b0;
		pulse(3'h1);
		repeat (10) @(posedge pclk);
		`CHK("disabled_depth", s, cpu.sp)
		irq_req <= '0;
		apb(1'b1, 8'h10, 32'h01FFFFFE);
		$display("test masked done");
	endtask
	// latched winner keeps its place against a later, higher request
	task automatic t_hw;
		logic [7:0] s;
		s = cpu.sp;
		cpu_pc <= 16'h2000;
		irq_req <= 24'h000104;
		pulse(3'h1);
		irq_req[1] <= 1'b1;
		wait_vec(5'h04);
		`CHK("hw_addr", 16'hFFF6, vector_addr)
		`CHK("hw_pcl", 8'hFF, cpu.mem[s])
		`CHK("hw_pch", 8'h1F, cpu.mem[s - 8'h01])
		irq_req <= '0;
		$display("test hw done");
	endtask
	// reset in mid-stack pre-empts the entry
	task automatic t_reset;
		i_mask <= 1'b1;
		pulse(3'h4);
		repeat (2) @(posedge pclk);
		reset_req <= 1'b1;
		@(posedge pclk);
		reset_req <= 1'b0;
		@(posedge pclk);
		`CHK("reset_take", 1'b1, reset_take)
		`CHK("reset_code", 5'h00, vector_code)
		$display("test reset done");
	endtask
	// counts and verdict
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// hang guard well beyond the hundred or so cycles the tests need
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fail_count++;
			wrap_up;
		end
	end
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, irq_req} = '0;
		{reset_req, instr_done, i_mask, swi_exec, rti_exec} = '0;
		{ce, cpu_pc, cpu_a, cpu_x, cpu_ccr} = {1'b1, 16'h1234, 24'hA15C00};
		{fail_count, n_checks, cyc} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_swi;
		t_rti;
		t_masked;
		t_hw;
		t_reset;
		wrap_up;
	end
endmodule
